// *** inc/rsv_pkg.sv ***
// Purpose : Shared constants and types for the clock supervisor block
// Assumes : 20 MHz system clock, supply levels arrive as comparator pins
// Notes   : Hold, watchdog and second counts are top-level parameters derived from these times

package rsv_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_NS          = 50;
    // Reset hold after supply recovery, in ms
    localparam int unsigned RST_HOLD_MS     = 200;
    localparam int unsigned RST_HOLD_CYC    = RST_HOLD_MS * (CLK_HZ / 1000);
    // Shortest periodic interval, in ns (30.5 us), rounded down
    localparam int unsigned PER_MIN_NS      = 30_500;
    localparam int unsigned PER_MIN_CYC     = PER_MIN_NS / CLK_NS;
    // Longest periodic interval, in ms
    localparam int unsigned PER_MAX_MS      = 500;
    localparam int unsigned PER_MAX_CYC     = PER_MAX_MS * (CLK_HZ / 1000);
    // Warning lead before reset asserts on supply fail
    localparam int unsigned WARN_LEAD_CYC   = 2;
    // Default watchdog time-out, in ms
    localparam int unsigned WDOG_MS         = 1500;
    localparam int unsigned WDOG_CYC        = WDOG_MS * (CLK_HZ / 1000);
    // One second of the timebase
    localparam int unsigned SEC_CYC         = CLK_HZ;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned DATA_W          = 8;
    localparam logic [7:0]  READ_RST        = 8'h00;

    // Supply state as seen by the monitor
    typedef enum logic [1:0] {
        SUP_GOOD   = 2'b00,   // Above power-fail threshold
        SUP_LOCK   = 2'b01,   // Below threshold, above switchover
        SUP_BATT   = 2'b10    // At or below switchover
    } rsv_sup_t;

    // Alarm repetition rate
    typedef enum logic [2:0] {
        ALM_SEC    = 3'b000,
        ALM_MIN    = 3'b001,
        ALM_HOUR   = 3'b010,
        ALM_DAY    = 3'b011,
        ALM_MONTH  = 3'b100
    } rsv_alm_t;

endpackage

// *** logic/rsv_top.sv ***
// Purpose : Supervisor, bus gating, alarm/periodic events, SRAM enable gating
// Assumes : Supply comparators and pins are asynchronous; one 20 MHz clock
// Notes   : Time counting is simplified; alarm rates use second counters

`timescale 1ns/1ps

module rsv_top #(
    parameter int unsigned RST_HOLD = rsv_pkg::RST_HOLD_CYC,  // Reset hold cycles
    parameter int unsigned WDOG_TO  = rsv_pkg::WDOG_CYC,      // Watchdog cycles
    parameter int unsigned SEC_LEN  = rsv_pkg::SEC_CYC        // Cycles per second
) (
    input  wire logic        clk_i,             // 20 MHz clock
    input  wire logic        rst_i,             // Async reset, high
    input  wire logic        ce_i,              // Clock enable
    input  wire logic        sup_ok_i,          // Supply above threshold
    input  wire logic        sup_batt_i,        // Supply at or below switchover
    input  wire logic        cs_n_i,            // Device select, low
    input  wire logic        oe_n_i,            // Output enable, low
    input  wire logic        we_n_i,            // Write enable, low
    input  wire logic [3:0]  addr_i,            // Address
    input  wire logic [7:0]  dq_i,              // Data in
    input  wire logic        ram_ce_n_i,        // SRAM enable in
    input  wire logic        watchdog_kick_input_i,     // Kick level
    input  wire logic        kick_present_i,    // Kick pin connected
    input  wire logic [31:0] wdog_to_i,         // Programmed time-out, 0 = default
    input  wire logic [2:0]  alm_rate_i,        // Alarm repetition
    input  wire logic        alm_batt_en_i,     // Alarm alive on battery
    input  wire logic [31:0] per_cyc_i,         // Periodic interval in cycles
    input  wire logic        per_en_i,          // Periodic enable
    output logic [7:0]       dq_o,              // Data out
    output logic             dq_oe_o,           // Data output enable
    output logic             ram_ce_n_o,        // SRAM enable out
    output logic             vout_cell_o,       // Cell feeds backup output
    output logic             warn_o,            // Power-fail warning
    output logic             cpu_rst_o,         // Processor reset
    output logic             watchdog_timeout_output_o, // Watchdog expired
    output logic             alarm_o,           // Alarm pulse
    output logic             periodic_o,        // Periodic pulse
    output logic [7:0]       wr_data_o,         // Last accepted write data
    output logic [3:0]       wr_addr_o,         // Last write address
    output logic             wr_stb_o           // Write accepted pulse
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  ok_s;      // Supply-good synchroniser
        logic [2:0]  bt_s;      // Battery synchroniser
        logic [2:0]  kk_s;      // Kick synchroniser
        logic [2:0]  kp_s;      // Kick-present synchroniser
        logic [2:0]  we_s;      // Write strobe synchroniser
        logic        ok;        // Filtered supply good
        logic        bt;        // Filtered battery level
        logic        kk;        // Filtered kick
        logic        kp;        // Filtered kick present
        logic        wl;        // Filtered write low
        logic        armed;     // Cell isolation broken
        logic        warn;
        logic [1:0]  lead;      // Warning lead counter
        logic        rst;
        logic [31:0] hold;      // Reset hold counter
        logic [31:0] wd;        // Watchdog counter
        logic        watchdog_timeout_output;
        logic [31:0] sec;       // Second prescaler
        logic [31:0] nsec;      // Seconds elapsed
        logic        alm;
        logic [31:0] per;       // Periodic counter
        logic        perp;
        logic [7:0]  wdat;
        logic [3:0]  wadr;
        logic        wstb;
        logic [7:0]  rdat;
    } rsv_st_t;

    rsv_st_t st_r;
    rsv_st_t st_nxt;

    // Value after reset: processor reset held, everything else clear
    localparam rsv_st_t ST_RST = '{rst: 1'b1, default: '0};

    // Seconds per alarm repetition
    function automatic logic [31:0] alm_secs(input logic [2:0] r);
        case (r)
            rsv_pkg::ALM_MIN:   alm_secs = 32'h0000_003C;
            rsv_pkg::ALM_HOUR:  alm_secs = 32'h0000_0E10;
            rsv_pkg::ALM_DAY:   alm_secs = 32'h0001_5180;
            rsv_pkg::ALM_MONTH: alm_secs = 32'h0027_8D00;
            default:            alm_secs = 32'h0000_0001;
        endcase
    endfunction

    // Clamp periodic interval into its legal range
    function automatic logic [31:0] per_clamp(input logic [31:0] v);
        if (v < 32'(rsv_pkg::PER_MIN_CYC)) begin
            per_clamp = 32'(rsv_pkg::PER_MIN_CYC);
        end else if (v > 32'(rsv_pkg::PER_MAX_CYC)) begin
            per_clamp = 32'(rsv_pkg::PER_MAX_CYC);
        end else begin
            per_clamp = v;
        end
    endfunction

    logic        sel_ok;   // Bus usable
    logic [31:0] wd_lim;   // Effective time-out

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        wd_lim = (wdog_to_i == 32'h0000_0000) ? 32'(WDOG_TO) : wdog_to_i;
        // Three-stage inputs; change counts when stages 2 and 3 agree
        st_nxt.ok_s = {st_r.ok_s[1:0], sup_ok_i};
        st_nxt.bt_s = {st_r.bt_s[1:0], sup_batt_i};
        st_nxt.kk_s = {st_r.kk_s[1:0], watchdog_kick_input_i};
        st_nxt.kp_s = {st_r.kp_s[1:0], kick_present_i};
        st_nxt.we_s = {st_r.we_s[1:0], ~we_n_i & ~cs_n_i};
        if (st_r.ok_s[2] == st_r.ok_s[1]) begin
            st_nxt.ok = st_r.ok_s[2];
        end
        if (st_r.bt_s[2] == st_r.bt_s[1]) begin
            st_nxt.bt = st_r.bt_s[2];
        end
        if (st_r.kk_s[2] == st_r.kk_s[1]) begin
            st_nxt.kk = st_r.kk_s[2];
        end
        if (st_r.kp_s[2] == st_r.kp_s[1]) begin
            st_nxt.kp = st_r.kp_s[2];
        end
        if (st_r.we_s[2] == st_r.we_s[1]) begin
            st_nxt.wl = st_r.we_s[2];
        end
        if (st_r.ok) begin
            st_nxt.armed = 1'b1;
        end
        if (!st_r.ok) begin
            st_nxt.warn = 1'b1;
            st_nxt.hold = 32'h0000_0000;
            if (st_r.lead != 2'(rsv_pkg::WARN_LEAD_CYC)) begin
                st_nxt.lead = st_r.lead + 2'b01;
            end else begin
                st_nxt.rst = 1'b1;
            end
        end else begin
            st_nxt.warn = 1'b0;
            st_nxt.lead = 2'b00;
            if (st_r.rst && !st_r.watchdog_timeout_output) begin
                if (st_r.hold >= 32'(RST_HOLD) - 32'h0000_0001) begin
                    st_nxt.rst  = 1'b0;
                    st_nxt.hold = 32'h0000_0000;
                end else begin
                    st_nxt.hold = st_r.hold + 32'h0000_0001;
                end
            end
        end
        if (!st_r.kp || !st_r.ok || st_r.kk != st_nxt.kk) begin
            st_nxt.wd  = 32'h0000_0000;
            st_nxt.watchdog_timeout_output = 1'b0;
        end else if (st_r.wd >= wd_lim - 32'h0000_0001) begin
            st_nxt.watchdog_timeout_output  = 1'b1;
            st_nxt.rst  = 1'b1;
            st_nxt.hold = 32'h0000_0000;
        end else begin
            st_nxt.wd = st_r.wd + 32'h0000_0001;
        end
        if (!st_r.kp) begin
            st_nxt.watchdog_timeout_output = 1'b0;
        end
        st_nxt.alm = 1'b0;
        if (st_r.sec >= 32'(SEC_LEN) - 32'h0000_0001) begin
            st_nxt.sec = 32'h0000_0000;
            if (st_r.nsec >= alm_secs(alm_rate_i) - 32'h0000_0001) begin
                st_nxt.nsec = 32'h0000_0000;
                st_nxt.alm  = st_r.ok || alm_batt_en_i;
            end else begin
                st_nxt.nsec = st_r.nsec + 32'h0000_0001;
            end
        end else begin
            st_nxt.sec = st_r.sec + 32'h0000_0001;
        end
        st_nxt.perp = 1'b0;
        if (!per_en_i) begin
            st_nxt.per = 32'h0000_0000;
        end else if (st_r.per >= per_clamp(per_cyc_i) - 32'h0000_0001) begin
            st_nxt.per  = 32'h0000_0000;
            st_nxt.perp = 1'b1;
        end else begin
            st_nxt.per = st_r.per + 32'h0000_0001;
        end
        // Accept write on filtered strobe edge
        st_nxt.wstb = 1'b0;
        if (sel_ok && st_nxt.wl && !st_r.wl) begin
            st_nxt.wdat = dq_i;
            st_nxt.wadr = addr_i;
            st_nxt.wstb = 1'b1;
        end
        // Read data: latched write value if address is the last write address, else READ_RST
        st_nxt.rdat = (addr_i == st_r.wadr) ? st_r.wdat : rsv_pkg::READ_RST;
    end

    // ------------------------------------------------------------
    // Bus gating
    // ------------------------------------------------------------
    // Bus ignored below threshold
    assign sel_ok = st_r.ok && !st_r.bt;

    always_comb begin
        // Drive only with OE low, WE high
        dq_oe_o = sel_ok && !cs_n_i && we_n_i && !oe_n_i;
        dq_o    = st_r.rdat;
        ram_ce_n_o = sel_ok ? ram_ce_n_i : 1'b1;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= ST_RST;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Cell feeds output in battery mode once armed
    // Between threshold and switchover the supply still feeds the output
    assign vout_cell_o               = st_r.armed && st_r.bt;
    assign warn_o                    = st_r.warn;
    assign cpu_rst_o                 = st_r.rst;
    assign watchdog_timeout_output_o = st_r.watchdog_timeout_output;
    assign alarm_o                   = st_r.alm;
    assign periodic_o                = st_r.perp;
    assign wr_data_o                 = st_r.wdat;
    assign wr_addr_o                 = st_r.wadr;
    assign wr_stb_o                  = st_r.wstb;

endmodule

// *** testbench/rsv_chk.sv ***
// Purpose: port assertions for the supervisor block
// Assumes: parameters follow the bound instance
// Notes: supply checks leave room for the input filter
`timescale 1ns/1ps
module rsv_chk #(parameter int unsigned RST_HOLD = 20, parameter int unsigned WDOG_TO = 50) (
    input wire logic        clk_i, rst_i, sup_ok_i, sup_batt_i, cs_n_i, oe_n_i, we_n_i,
    input wire logic        ram_ce_n_i, watchdog_kick_input_i, kick_present_i, alm_batt_en_i,
    input wire logic [31:0] wdog_to_i,
    input wire logic        dq_oe_o, ram_ce_n_o, vout_cell_o, warn_o, cpu_rst_o, alarm_o,
    input wire logic        watchdog_timeout_output_o, periodic_o, wr_stb_o
);
    // Raw kick idle count, good-supply run, first-good flag
    logic [31:0] idle_r, good_r, lim;
    logic        kick_r, seen_r;
    assign lim = (wdog_to_i == 0) ? WDOG_TO : wdog_to_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {idle_r, good_r, kick_r, seen_r} <= '0;
        end else begin
            kick_r <= watchdog_kick_input_i;
            idle_r <= (watchdog_kick_input_i != kick_r) ? '0 : idle_r + 1;
            good_r <= (sup_ok_i && !sup_batt_i) ? good_r + 1 : '0;
            seen_r <= seen_r | sup_ok_i;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_warn_first: assert property ($rose(cpu_rst_o) |-> (warn_o || watchdog_timeout_output_o)
        or ##1 watchdog_timeout_output_o)
        else $error("reset rose unwarned");
    a_warn_lead: assert property ($rose(warn_o) |-> ##[1:4] cpu_rst_o)
        else $error("no reset after warning");
    a_rst_hold: assert property ($fell(cpu_rst_o) |-> good_r >= RST_HOLD)
        else $error("reset released early");
    a_wdog_rst: assert property ($rose(watchdog_timeout_output_o) |-> ##[0:2] cpu_rst_o)
        else $error("timeout without reset");
    a_wdog_time: assert property ($rose(watchdog_timeout_output_o) |-> idle_r >= lim)
        else $error("timeout before limit");
    a_kick_off: assert property (!kick_present_i && !$past(kick_present_i, 6)
        |-> !$rose(watchdog_timeout_output_o))
        else $error("timeout while disabled");
    a_desel_float: assert property (cs_n_i |-> !dq_oe_o)
        else $error("driving while deselected");
    a_read_gate: assert property (dq_oe_o |-> !oe_n_i && we_n_i)
        else $error("driving outside read");
    a_ce_pass: assert property ((sup_ok_i && !sup_batt_i) [*6] |-> ram_ce_n_o == ram_ce_n_i)
        else $error("sram enable not passed");
    a_fail_lock: assert property ((!sup_ok_i) [*6] |-> ram_ce_n_o && !dq_oe_o && !wr_stb_o)
        else $error("bus active on bad supply");
    a_batt_cell: assert property ((seen_r && sup_batt_i) [*6] |-> vout_cell_o)
        else $error("cell not feeding output");
    a_cell_iso: assert property (!seen_r |-> !vout_cell_o)
        else $error("cell not isolated");
    a_alarm_off: assert property (!alm_batt_en_i && !$past(alm_batt_en_i) && sup_batt_i
        && $past(sup_batt_i, 6) |-> !alarm_o)
        else $error("alarm on battery disabled");
    c_wr: cover property (wr_stb_o);
    c_per: cover property (periodic_o);
    c_alm: cover property (alarm_o && sup_batt_i);
endmodule
bind rsv_top rsv_chk #(.RST_HOLD(RST_HOLD), .WDOG_TO(WDOG_TO)) u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .sup_ok_i(sup_ok_i), .sup_batt_i(sup_batt_i), .cs_n_i(cs_n_i),
    .oe_n_i(oe_n_i), .we_n_i(we_n_i), .ram_ce_n_i(ram_ce_n_i),
    .watchdog_kick_input_i(watchdog_kick_input_i), .kick_present_i(kick_present_i),
    .alm_batt_en_i(alm_batt_en_i), .wdog_to_i(wdog_to_i), .dq_oe_o(dq_oe_o),
    .ram_ce_n_o(ram_ce_n_o), .vout_cell_o(vout_cell_o), .warn_o(warn_o),
    .cpu_rst_o(cpu_rst_o), .alarm_o(alarm_o), .periodic_o(periodic_o), .wr_stb_o(wr_stb_o),
    .watchdog_timeout_output_o(watchdog_timeout_output_o));

// *** testbench/rsv_host.sv ***
// Purpose: host processor model on the bus and kick pin
// Assumes: changes land on the falling edge
// Notes: released strobes go high; address and data show the inverse of their last value
`timescale 1ns/1ps
module rsv_host (
    input  wire logic clk_i,
    input  wire logic wr_stb_i,
    output logic      cs_n_o,
    output logic      oe_n_o,
    output logic      we_n_o,
    output logic      kick_o,
    output logic [3:0] addr_o,
    output logic [7:0] dq_o
);
    initial begin
        {cs_n_o, oe_n_o, we_n_o, kick_o, addr_o, dq_o} = 16'hE000;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic oe);
        int t;
        t = 0;
        @(negedge clk_i);
        {cs_n_o, oe_n_o, we_n_o, addr_o, dq_o} = {1'b0, oe, 1'b0, a, d};
        // Hold until taken; give up if refused
        while (wr_stb_i !== 1'b1 && t < 12) begin
            @(negedge clk_i);
            t++;
        end
        idle();
        repeat (4) @(negedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic oe);
        @(negedge clk_i);
        {cs_n_o, oe_n_o, we_n_o, addr_o} = {1'b0, oe, 1'b1, a};
        repeat (3) @(negedge clk_i);
    endtask
    task automatic idle();
        {cs_n_o, oe_n_o, we_n_o} = 3'h7;
        addr_o = ~addr_o;
        dq_o = ~dq_o;
    endtask
    task automatic kick();
        @(negedge clk_i);
        kick_o = ~kick_o;
    endtask
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the supervisor block
// Assumes: short counts: hold 20, watchdog 50, second 10 cycles
// Notes: writes are checked from a queue when the strobe shows
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module tb;
    logic clk_i = 0, rst_i = 1, ce_i = 1, sup_ok_i = 0, sup_batt_i = 1, ram_ce_n_i = 0;
    logic kick_present_i = 0, alm_batt_en_i = 0, per_en_i = 0;
    logic [31:0] wdog_to_i = '0, per_cyc_i = '0;
    logic [2:0] alm_rate_i = '0;
    logic cs_n_i, oe_n_i, we_n_i, watchdog_kick_input_i, dq_oe_o, ram_ce_n_o, vout_cell_o;
    logic warn_o, cpu_rst_o, watchdog_timeout_output_o, alarm_o, periodic_o, wr_stb_o;
    logic [3:0] addr_i, wr_addr_o;
    logic [7:0] dq_i, dq_o, wr_data_o, lfsr = 8'h2A;
    logic [11:0] exp_q[$], exp_w;
    int mismatches = 0, tests_run = 0, cyc = 0, n;
    rsv_top #(.RST_HOLD(20), .WDOG_TO(50), .SEC_LEN(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .sup_ok_i(sup_ok_i), .sup_batt_i(sup_batt_i), .cs_n_i(cs_n_i),
        .oe_n_i(oe_n_i), .we_n_i(we_n_i), .addr_i(addr_i), .dq_i(dq_i),
        .ram_ce_n_i(ram_ce_n_i), .watchdog_kick_input_i(watchdog_kick_input_i),
        .kick_present_i(kick_present_i), .wdog_to_i(wdog_to_i), .alm_rate_i(alm_rate_i),
        .alm_batt_en_i(alm_batt_en_i), .per_cyc_i(per_cyc_i), .per_en_i(per_en_i),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .ram_ce_n_o(ram_ce_n_o), .vout_cell_o(vout_cell_o),
        .warn_o(warn_o), .cpu_rst_o(cpu_rst_o),
        .watchdog_timeout_output_o(watchdog_timeout_output_o), .alarm_o(alarm_o),
        .periodic_o(periodic_o), .wr_data_o(wr_data_o), .wr_addr_o(wr_addr_o),
        .wr_stb_o(wr_stb_o));
    rsv_host u_host (.clk_i(clk_i), .wr_stb_i(wr_stb_o), .cs_n_o(cs_n_i), .oe_n_o(oe_n_i),
        .we_n_o(we_n_i), .kick_o(watchdog_kick_input_i), .addr_o(addr_i), .dq_o(dq_i));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, well above the planned run
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    // Oldest write note against each strobe
    always @(negedge clk_i) begin
        if (wr_stb_o === 1'b1) begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            `CHK("write", exp_w, {wr_addr_o, wr_data_o})
        end
    end
    task automatic wait_for(ref logic s, input logic v, input int lim, output int t);
        t = 0;
        while (s !== v && t < lim) begin
            @(negedge clk_i);
            t++;
        end
    endtask
    // Cycles between two pulses
    task automatic gap(ref logic s, output int t);
        wait_for(s, 1'b1, 2000, t);
        @(negedge clk_i);
        wait_for(s, 1'b1, 2000, t);
        t++;
    endtask
    task automatic wd_run(input int lim);
        // Measure from a fresh kick edge, filter delay included
        u_host.kick();
        wait_for(watchdog_timeout_output_o, 1'b1, lim + 40, n);
        `CHK("wdo_time", 1'b1, n >= lim && n <= lim + 12)
        repeat (3) @(negedge clk_i);
        `CHK("wdo_rst", 1'b1, cpu_rst_o)
        u_host.kick();
        wait_for(cpu_rst_o, 1'b0, 40, n);
        `CHK("wdo_clear", 1'b0, watchdog_timeout_output_o)
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        rst_i = 0;
        repeat (12) @(negedge clk_i);
        `CHK("cell_iso", 2'h1, {vout_cell_o, ram_ce_n_o})
        {sup_batt_i, sup_ok_i} = 2'h1;
        wait_for(cpu_rst_o, 1'b0, 60, n);
        `CHK("rst_hold", 1'b1, n >= 20 && n <= 30)
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            exp_q.push_back({i[3:0], lfsr});
            u_host.wr(i[3:0], lfsr, i[0]);
        end
        u_host.rd(4'h3, 1'b0);
        `CHK("rd_data", {1'b1, lfsr}, {dq_oe_o, dq_o})
        u_host.rd(4'h3, 1'b1);
        `CHK("rd_float", 1'b0, dq_oe_o)
        u_host.idle();
        for (int v = 0; v < 2; v++) begin
            ram_ce_n_i = v[0];
            @(negedge clk_i);
            `CHK("desel", {1'b0, v[0]}, {dq_oe_o, ram_ce_n_o})
        end
        kick_present_i = 1;
        repeat (5) begin
            u_host.kick();
            repeat (30) @(negedge clk_i);
        end
        `CHK("wdo_quiet", 1'b0, watchdog_timeout_output_o)
        wd_run(50);
        wdog_to_i = 32'h0000_001E;
        wd_run(30);
        kick_present_i = 0;
        repeat (100) @(negedge clk_i);
        `CHK("wdo_off", 1'b0, watchdog_timeout_output_o)
        for (int r = 0; r < 5; r++) begin
            @(negedge clk_i);
            alm_rate_i = r[2:0];
            if (r < 2) begin
                gap(alarm_o, n);
                `CHK("alm_gap", r ? 600 : 10, n)
            end
        end
        per_en_i = 1;
        for (int k = 0; k < 2; k++) begin
            per_cyc_i = k ? 32'h0000_0320 : 32'h0000_0005;
            gap(periodic_o, n);
            `CHK("per_gap", k ? 800 : 610, n)
        end
        per_en_i = 0;
        alm_rate_i = 3'h0;
        alm_batt_en_i = 1;
        ram_ce_n_i = 0;
        sup_ok_i = 0;
        wait_for(warn_o, 1'b1, 10, n);
        `CHK("warn_first", 2'h2, {warn_o, cpu_rst_o})
        wait_for(cpu_rst_o, 1'b1, 8, n);
        `CHK("fail_rst", 1'b1, cpu_rst_o)
        u_host.wr(4'h3, ~lfsr, 1'b1);
        u_host.rd(4'h3, 1'b0);
        `CHK("lock", 3'h2, {dq_oe_o, ram_ce_n_o, vout_cell_o})
        u_host.idle();
        sup_batt_i = 1;
        gap(alarm_o, n);
        `CHK("batt", 3'h6, {vout_cell_o, ram_ce_n_o, dq_oe_o})
        `CHK("alm_batt", 10, n)
        alm_batt_en_i = 0;
        repeat (30) @(negedge clk_i);
        {sup_batt_i, sup_ok_i} = 2'h1;
        // Frozen clock enable must stall the reset hold count
        repeat (10) @(negedge clk_i);
        ce_i = 0;
        repeat (40) @(negedge clk_i);
        `CHK("freeze", 1'b1, cpu_rst_o)
        ce_i = 1;
        wait_for(cpu_rst_o, 1'b0, 60, n);
        u_host.rd(4'h3, 1'b0);
        `CHK("rd_keep", {1'b1, lfsr}, {dq_oe_o, dq_o})
        u_host.idle();
        `CHK("queue", 0, exp_q.size())
        tally_and_finish();
    end
endmodule
